/* bench/sfx_props.sv */
`timescale 1ns/1ps
module sfx_props import sfx_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Request
  input wire logic op_valid,
  input wire sfx_op_t op_code,
  input wire logic [7:0] op_imm,
  // Result
  input wire logic flags_valid,
  input wire logic [5:0] flags_possible
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property pm(c, f); op_valid && c |=> flags_valid && flags_possible == f; endproperty
  as_dbl_a: assert property (pm(op_code == 3, 6'h3B)) else $error("bad");
  as_sgl_a: assert property (pm(op_code == 4, 6'h3B)) else $error("bad");
  h_add_a: assert property (pm(op_code[3:1] == 3, 6'h3B)) else $error("bad");
  h_sub_a: assert property (pm(op_code[3:1] == 4, 6'h3B)) else $error("bad");
  dot_prod_a: assert property (pm(op_code[3:1] == 5, 6'h3B)) else $error("bad");
  rnd_prec_a: assert property (pm(op_code > 11 && !op_imm[3], 6'h21)) else $error("bad");
  rnd_sup_a: assert property (pm(op_code > 11 && op_imm[3], 6'h01)) else $error("bad");
  no_flags_a: assert property (pm(op_code < 3, 6'h00)) else $error("bad");
  cover property (op_valid ##1 op_valid);
  cover property (op_valid && op_code > 11 && op_imm[3]);
  cover property (flags_valid && flags_possible == 6'h3B);
endmodule // sfx_props
bind sfx_classifier sfx_props sfx_props_inst (.*);

/* bench/test_sfx_classifier.sv */
`timescale 1ns/1ps
module test_sfx_classifier;
  import sfx_pkg::*;
  logic clk_sys = 0, sys_rst = 1, op_valid = 0, flags_valid;
  logic [7:0] op_imm = 8'h00;
  logic [5:0] flags_possible;
  wire [6:0] res = {flags_valid, flags_possible};
  sfx_op_t op_code = SFX_OP_INT_EXT;
  int n_errors = 0, comparisons = 0, cyc = 0;
  sfx_classifier sfx_classifier_inst (.*);
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [6:0] want(logic v, logic b3);
    if (!v) return 7'h00;
    if (op_code < 3) return 7'h40;
    if (op_code > 11) return b3 ? 7'h41 : 7'h61;
    return op_code == 5 ? 7'h61 : 7'h7B;
  endfunction
  task automatic chk(logic [6:0] seen, exp);
    comparisons++;
    n_errors += int'(seen !== exp);
    if (seen !== exp) $display("MISMATCH %0t %h %h", $time, seen, exp);
  endtask
  task automatic test_done;
    $display("%0d errors %0d checks", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic req(int o, logic [7:0] i, logic v);
    op_code = sfx_op_t'(o[3:0]);
    {op_imm, op_valid} = {i, v};
    @(negedge clk_sys);
    chk(res, want(v, i[3]));
  endtask
  initial begin
    void'($urandom(32'h0000_41cd));
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    for (int k = 0; k < 32; k++) req(k, {4'h0, k[4], 3'h0}, 1'b1);
    repeat (300) req($urandom, 8'($urandom), 1'($urandom));
    test_done();
  end
  always @(posedge clk_sys) if (++cyc == 2000) begin
    n_errors++;
    test_done();
  end
endmodule // test_sfx_classifier

/* core/sfx_classifier.sv */
`timescale 1ns/1ps
module sfx_classifier
  import sfx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Instruction request
  input wire logic op_valid,
  input wire sfx_pkg::sfx_op_t op_code,
  input wire logic [sfx_pkg::IMM_W-1:0] op_imm,
  // Classification result
  output logic flags_valid,
  output logic [sfx_pkg::FLAG_W-1:0] flags_possible
);
  import sfx_pkg::*;

  sfx_req_if req ();

  assign req.valid = op_valid;
  assign req.op = op_code;
  assign req.imm = op_imm;

  sfx_lookup u_lookup (
    .req(req)
  );

  // Operation groups, decoded apart from the table so that a wrong table entry cannot
  // raise a flag that the group of the operation never raises.
  logic grp_addsub_double;
  logic grp_addsub_single;
  logic grp_horiz_add;
  logic grp_horiz_sub;
  logic grp_dot;
  logic grp_round;
  logic grp_trunc;
  logic grp_ext3_other;
  logic grp_int_ext;
  logic grp_ext4_other;

  always_comb begin
    grp_addsub_double = 1'b0;
    grp_addsub_single = 1'b0;
    grp_horiz_add = 1'b0;
    grp_horiz_sub = 1'b0;
    grp_dot = 1'b0;
    grp_round = 1'b0;
    grp_trunc = 1'b0;
    grp_ext3_other = 1'b0;
    grp_int_ext = 1'b0;
    grp_ext4_other = 1'b0;
    unique case (op_code)
      SFX_OP_ALT_ADDSUB_PACKED_DOUBLE: begin
        grp_addsub_double = 1'b1;
      end
      SFX_OP_ALT_ADDSUB_PACKED_SINGLE: begin
        grp_addsub_single = 1'b1;
      end
      SFX_OP_HORIZ_ADD_DOUBLE: begin
        grp_horiz_add = 1'b1;
      end
      SFX_OP_HORIZ_ADD_SINGLE: begin
        grp_horiz_add = 1'b1;
      end
      SFX_OP_HORIZ_SUB_DOUBLE: begin
        grp_horiz_sub = 1'b1;
      end
      SFX_OP_HORIZ_SUB_SINGLE: begin
        grp_horiz_sub = 1'b1;
      end
      SFX_OP_DOT_PRODUCT_DOUBLE: begin
        grp_dot = 1'b1;
      end
      SFX_OP_DOT_PRODUCT_SINGLE: begin
        grp_dot = 1'b1;
      end
      SFX_OP_ROUND_PACKED_DOUBLE: begin
        grp_round = 1'b1;
      end
      SFX_OP_ROUND_PACKED_SINGLE: begin
        grp_round = 1'b1;
      end
      SFX_OP_ROUND_SCALAR_DOUBLE: begin
        grp_round = 1'b1;
      end
      SFX_OP_ROUND_SCALAR_SINGLE: begin
        grp_round = 1'b1;
      end
      SFX_OP_TRUNCATING_INT_STORE: begin
        grp_trunc = 1'b1;
      end
      SFX_OP_OTHER_EXT3: begin
        grp_ext3_other = 1'b1;
      end
      SFX_OP_INT_EXT: begin
        grp_int_ext = 1'b1;
      end
      SFX_OP_OTHER_EXT4: begin
        grp_ext4_other = 1'b1;
      end
    endcase
  end

  // Extension family of each operation. A flag-raising group only counts inside its own family, which
  // keeps the silent integer set fenced off even if a group decode is mis-wired.
  logic fam_ext3;
  logic fam_int_ext;
  logic fam_ext4;

  always_comb begin
    fam_ext3 = 1'b0;
    fam_int_ext = 1'b0;
    fam_ext4 = 1'b0;
    unique case (op_code)
      SFX_OP_OTHER_EXT3: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_INT_EXT: begin
        fam_int_ext = 1'b1;
      end
      SFX_OP_OTHER_EXT4: begin
        fam_ext4 = 1'b1;
      end
      SFX_OP_ALT_ADDSUB_PACKED_DOUBLE: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_ALT_ADDSUB_PACKED_SINGLE: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_TRUNCATING_INT_STORE: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_HORIZ_ADD_DOUBLE: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_HORIZ_ADD_SINGLE: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_HORIZ_SUB_DOUBLE: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_HORIZ_SUB_SINGLE: begin
        fam_ext3 = 1'b1;
      end
      SFX_OP_DOT_PRODUCT_DOUBLE: begin
        fam_ext4 = 1'b1;
      end
      SFX_OP_DOT_PRODUCT_SINGLE: begin
        fam_ext4 = 1'b1;
      end
      SFX_OP_ROUND_PACKED_DOUBLE: begin
        fam_ext4 = 1'b1;
      end
      SFX_OP_ROUND_PACKED_SINGLE: begin
        fam_ext4 = 1'b1;
      end
      SFX_OP_ROUND_SCALAR_DOUBLE: begin
        fam_ext4 = 1'b1;
      end
      SFX_OP_ROUND_SCALAR_SINGLE: begin
        fam_ext4 = 1'b1;
      end
    endcase
  end

  // Group hits qualified by their family, except the quiet set, which takes family and groups unqualified.
  logic arith_op;
  logic round_op;
  logic trunc_op;
  logic quiet_op;
  logic round_prec_masked;

  assign arith_op = (fam_ext3 & (grp_addsub_double | grp_addsub_single)) |
    (fam_ext3 & (grp_horiz_add | grp_horiz_sub)) |
    (fam_ext4 & grp_dot);
  assign round_op = fam_ext4 & grp_round;
  assign trunc_op = fam_ext3 & grp_trunc;
  assign quiet_op = fam_int_ext | grp_int_ext |
    grp_ext3_other | grp_ext4_other;
  // A set immediate bit takes precision out of a round operation's set.
  assign round_prec_masked = round_op & op_imm[ROUND_IMM_SUPPRESS_BIT];

  logic [FLAG_W-1:0] bound_mask;
  logic [FLAG_W-1:0] next_flags_possible;

  // One slice per flag: the union of what the active group may raise, cut by the table.
  for (genvar b = 0; b < FLAG_W; b++) begin : g_flag
    // Divide-by-zero is in no group's set, so its slice stays low for every operation.
    localparam bit ARITH_OK = FLAGS_ARITH[b] && (b != FLAG_DIVZ);
    localparam bit INV_OK = FLAGS_INV_ONLY[b];
    localparam bit PREC_OK = FLAGS_INV_PREC[b] && !FLAGS_INV_ONLY[b];
    logic arith_hit;
    logic inv_hit;
    logic prec_hit;

    assign arith_hit = arith_op & ARITH_OK;
    assign inv_hit = (round_op | trunc_op) & INV_OK;
    assign prec_hit = ((round_op & ~round_prec_masked) | trunc_op) & PREC_OK;
    assign bound_mask[b] = ~quiet_op & (arith_hit | inv_hit | prec_hit);
    assign next_flags_possible[b] = req.flags[b] & bound_mask[b];
  end

  // Registered so the result meets timing into the flag merge stage.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_valid <= 1'b0;
    end else begin
      flags_valid <= op_valid;
    end
  end

  // Flags fall back to zero between requests so a consumer may merge them unqualified.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_possible <= FLAGS_NONE;
    end else if (op_valid) begin
      flags_possible <= next_flags_possible;
    end else begin
      flags_possible <= FLAGS_NONE;
    end
  end
endmodule // sfx_classifier

/* core/sfx_lookup.sv */
`timescale 1ns/1ps
module sfx_lookup
  import sfx_pkg::*;
(
  sfx_req_if.dst req
);
  import sfx_pkg::*;

  always_comb begin
    req.flags = FLAGS_NONE;
    unique case (req.op)
      SFX_OP_ALT_ADDSUB_PACKED_DOUBLE: req.flags = FLAGS_ARITH;
      SFX_OP_ALT_ADDSUB_PACKED_SINGLE: req.flags = FLAGS_ARITH;
      SFX_OP_HORIZ_ADD_DOUBLE,
      SFX_OP_HORIZ_ADD_SINGLE: req.flags = FLAGS_ARITH;
      SFX_OP_HORIZ_SUB_DOUBLE,
      SFX_OP_HORIZ_SUB_SINGLE: req.flags = FLAGS_ARITH;
      SFX_OP_DOT_PRODUCT_DOUBLE,
      SFX_OP_DOT_PRODUCT_SINGLE: req.flags = FLAGS_ARITH;
      SFX_OP_TRUNCATING_INT_STORE: req.flags = FLAGS_INV_PREC;
      SFX_OP_ROUND_PACKED_DOUBLE,
      SFX_OP_ROUND_PACKED_SINGLE,
      SFX_OP_ROUND_SCALAR_DOUBLE,
      SFX_OP_ROUND_SCALAR_SINGLE: begin
        // A set immediate bit masks precision, invalid is always possible.
        req.flags = req.imm[ROUND_IMM_SUPPRESS_BIT] ? FLAGS_INV_ONLY : FLAGS_INV_PREC;
      end
      SFX_OP_OTHER_EXT3: req.flags = FLAGS_NONE;
      SFX_OP_INT_EXT: req.flags = FLAGS_NONE;
      SFX_OP_OTHER_EXT4: req.flags = FLAGS_NONE;
    endcase
    // An idle request answers with no flags, so a stale operation code cannot leak out.
    if (!req.valid) begin
      req.flags = FLAGS_NONE;
    end
  end
endmodule // sfx_lookup

/* core/sfx_pkg.sv */
package sfx_pkg;
  // Exception flag vector positions.
  localparam int FLAG_W = 6;
  localparam int FLAG_INV = 0;
  localparam int FLAG_DEN = 1;
  localparam int FLAG_DIVZ = 2;
  localparam int FLAG_OVF = 3;
  localparam int FLAG_UNF = 4;
  localparam int FLAG_PREC = 5;
  // Immediate bit that suppresses precision on round operations.
  localparam int ROUND_IMM_SUPPRESS_BIT = 3;
  localparam int IMM_W = 8;
  localparam logic [5:0] FLAGS_NONE = 6'h00;
  localparam logic [5:0] FLAGS_ARITH = 6'h3B;
  localparam logic [5:0] FLAGS_INV_PREC = 6'h21;
  localparam logic [5:0] FLAGS_INV_ONLY = 6'h01;

  typedef enum logic [3:0] {
    SFX_OP_OTHER_EXT3,
    SFX_OP_INT_EXT,
    SFX_OP_OTHER_EXT4,
    SFX_OP_ALT_ADDSUB_PACKED_DOUBLE,
    SFX_OP_ALT_ADDSUB_PACKED_SINGLE,
    SFX_OP_TRUNCATING_INT_STORE,
    SFX_OP_HORIZ_ADD_DOUBLE,
    SFX_OP_HORIZ_ADD_SINGLE,
    SFX_OP_HORIZ_SUB_DOUBLE,
    SFX_OP_HORIZ_SUB_SINGLE,
    SFX_OP_DOT_PRODUCT_DOUBLE,
    SFX_OP_DOT_PRODUCT_SINGLE,
    SFX_OP_ROUND_PACKED_DOUBLE,
    SFX_OP_ROUND_PACKED_SINGLE,
    SFX_OP_ROUND_SCALAR_DOUBLE,
    SFX_OP_ROUND_SCALAR_SINGLE
  } sfx_op_t;
endpackage

/* core/sfx_req_if.sv */
`timescale 1ns/1ps
interface sfx_req_if;
  import sfx_pkg::*;
  logic valid;
  sfx_op_t op;
  logic [IMM_W-1:0] imm;
  logic [FLAG_W-1:0] flags;
  modport src (output valid, output op, output imm, input flags);
  modport dst (input valid, input op, input imm, output flags);
endinterface
